// File: core/phy_fifo_an_prbs_regs.sv
// Register slice: RGMII FIFO control, serial link negotiation status, PRBS TX checker.
// Assumes a single-cycle register port and status inputs from the PHY datapath.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module phy_fifo_an_prbs_regs (
    input  wire logic                              clk,
    input  wire logic                              rstn,
    // Register port
    input  wire logic [7:0]                        reg_addr,
    input  wire logic [15:0]                       reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [15:0]                       reg_rdata,
    // Neighbouring register low threshold bits
    input  wire logic [1:0]                        rx_fifo_threshold_low_bits,
    input  wire logic [1:0]                        tx_fifo_threshold_low_bits,
    // Serial link negotiation status from the SGMII block
    input  wire logic                              serial_page_received,
    input  wire logic                              serial_link_negotiation_done,
    // PRBS checker datapath status
    input  wire logic                              checker_byte_valid,
    input  wire logic                              checker_byte_error,
    input  wire logic                              checker_sync_event,
    input  wire logic                              checker_lock_in,
    // RGMII data paths
    input  wire logic                              rx_in_valid,
    input  wire logic [phy_regs_pkg::FIFO_DW-1:0]  rx_in_data,
    output logic                                   rx_in_ready,
    output logic                                   rx_out_valid,
    output logic      [phy_regs_pkg::FIFO_DW-1:0]  rx_out_data,
    input  wire logic                              tx_in_valid,
    input  wire logic [phy_regs_pkg::FIFO_DW-1:0]  tx_in_data,
    output logic                                   tx_in_ready,
    output logic                                   tx_out_valid,
    output logic      [phy_regs_pkg::FIFO_DW-1:0]  tx_out_data,
    // Mode controls to the clocking and datapath
    output logic                                   async_fifo_skip_on,
    output logic                                   async_fifo_skip_delay_on,
    output logic                                   low_latency_on,
    output logic                                   checker_on
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers for status coming from other clock domains
    // ------------------------------------------------------------------
    logic [3:0] stat_meta_ff;
    logic [3:0] stat_sync_ff;
    logic [3:0] stat_raw;
    logic       page_seen_ff;
    logic       page_rise;

    assign stat_raw = {checker_lock_in, checker_sync_event,
                       serial_link_negotiation_done, serial_page_received};

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            stat_meta_ff <= 4'h0;
            stat_sync_ff <= 4'h0;
            page_seen_ff <= 1'b0;
        end else begin
            stat_meta_ff <= stat_raw;
            stat_sync_ff <= stat_meta_ff;
            page_seen_ff <= stat_sync_ff[0];
        end
    end

    assign page_rise = stat_sync_ff[0] & ~page_seen_ff;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [4:0]  fifo_ctrl_ff, nxt_fifo_ctrl;
    logic [1:0]  chk_ctrl_ff, nxt_chk_ctrl;
    logic        page_rx_ff, nxt_page_rx;
    logic        sync_lost_ff, nxt_sync_lost;
    logic        lock_pulse_ff, nxt_lock_pulse;
    logic        lock_clear_ff, nxt_lock_clear;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [7:0]  err_snap;
    logic [15:0] byte_snap;
    logic        byte_overflow;
    logic [15:0] fifo_word;
    logic [15:0] neg_word;
    logic [15:0] chk_word;
    logic        rd_neg;
    logic        rd_chk;

    always_comb begin
        // Reserved bits stay zero in every read word
        fifo_word = {11'h000, fifo_ctrl_ff};
        neg_word  = 16'h0000;
        neg_word[phy_regs_pkg::PAGE_RX_BIT]  = page_rx_ff;
        neg_word[phy_regs_pkg::NEG_DONE_BIT] = stat_sync_ff[1];
        chk_word  = 16'h0000;
        chk_word[phy_regs_pkg::ERR_CNT_MSB:phy_regs_pkg::ERR_CNT_LSB] = err_snap;
        chk_word[phy_regs_pkg::SYNC_LOST_BIT]  = sync_lost_ff;
        chk_word[phy_regs_pkg::LOCKED_BIT]     = stat_sync_ff[3];
        chk_word[phy_regs_pkg::BYTE_OVF_BIT]   = byte_overflow;
        chk_word[phy_regs_pkg::COUNT_MODE_BIT] = chk_ctrl_ff[1];
        chk_word[phy_regs_pkg::CHECKER_ON_BIT] = chk_ctrl_ff[0];

        rd_neg = reg_rd && (reg_addr == phy_regs_pkg::SGMII_NEGOTIATION_STATUS_ADDR);
        rd_chk = reg_rd && (reg_addr == phy_regs_pkg::PRBS_TX_CHECKER_CTRL_ADDR);

        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                phy_regs_pkg::RGMII_FIFO_CTRL_EXT_ADDR:        nxt_rdata = fifo_word;
                phy_regs_pkg::SGMII_NEGOTIATION_STATUS_ADDR:   nxt_rdata = neg_word;
                phy_regs_pkg::PRBS_TX_CHECKER_CTRL_ADDR:       nxt_rdata = chk_word;
                phy_regs_pkg::PRBS_TX_CHECKER_BYTE_COUNT_ADDR: nxt_rdata = byte_snap;
                default:                                       nxt_rdata = 16'h0000;
            endcase
        end

        nxt_fifo_ctrl  = fifo_ctrl_ff;
        nxt_chk_ctrl   = chk_ctrl_ff;
        nxt_lock_pulse = 1'b0;
        nxt_lock_clear = 1'b0;
        if (reg_wr && reg_addr == phy_regs_pkg::RGMII_FIFO_CTRL_EXT_ADDR) begin
            nxt_fifo_ctrl = reg_wdata[4:0];
        end
        if (reg_wr && reg_addr == phy_regs_pkg::PRBS_TX_CHECKER_CTRL_ADDR) begin
            nxt_chk_ctrl   = reg_wdata[1:0];
            nxt_lock_pulse = reg_wdata[phy_regs_pkg::LOCK_WR_BIT];
            nxt_lock_clear = reg_wdata[phy_regs_pkg::LOCK_CLEAR_WR_BIT];
        end

        // Sticky flags clear on read; a new event in the same cycle wins
        nxt_page_rx   = (page_rx_ff & ~rd_neg) | page_rise;
        nxt_sync_lost = (sync_lost_ff & ~rd_chk) | stat_sync_ff[2];
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fifo_ctrl_ff  <= phy_regs_pkg::RGMII_FIFO_CTRL_EXT_RST[4:0];
            chk_ctrl_ff   <= phy_regs_pkg::PRBS_TX_CHECKER_CTRL_RST[1:0];
            page_rx_ff    <= 1'b0;
            sync_lost_ff  <= 1'b0;
            lock_pulse_ff <= 1'b0;
            lock_clear_ff <= 1'b0;
            rdata_ff      <= 16'h0000;
        end else begin
            fifo_ctrl_ff  <= nxt_fifo_ctrl;
            chk_ctrl_ff   <= nxt_chk_ctrl;
            page_rx_ff    <= nxt_page_rx;
            sync_lost_ff  <= nxt_sync_lost;
            lock_pulse_ff <= nxt_lock_pulse;
            lock_clear_ff <= nxt_lock_clear;
            rdata_ff      <= nxt_rdata;
        end
    end

    assign reg_rdata                = rdata_ff;
    assign async_fifo_skip_on       = fifo_ctrl_ff[phy_regs_pkg::ASYNC_SKIP_BIT];
    assign async_fifo_skip_delay_on = fifo_ctrl_ff[phy_regs_pkg::ASYNC_SKIP_DELAY_BIT];
    assign low_latency_on           = fifo_ctrl_ff[phy_regs_pkg::LOW_LATENCY_BIT];
    assign checker_on               = chk_ctrl_ff[phy_regs_pkg::CHECKER_ON_BIT];

    // ------------------------------------------------------------------
    // Sync FIFOs and checker counters
    // ------------------------------------------------------------------
    logic [2:0] rx_threshold;
    logic [2:0] tx_threshold;

    assign rx_threshold = {fifo_ctrl_ff[phy_regs_pkg::RX_THR_TOP_BIT],
                           rx_fifo_threshold_low_bits};
    assign tx_threshold = {fifo_ctrl_ff[phy_regs_pkg::TX_THR_TOP_BIT],
                           tx_fifo_threshold_low_bits};

    // Data outputs are combinational through the skip path so that skipping adds no cycle
    sync_fifo_thr u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n_ff),
        .threshold (rx_threshold),
        .skip      (async_fifo_skip_on),
        .in_valid  (rx_in_valid),
        .in_data   (rx_in_data),
        .in_ready  (rx_in_ready),
        .out_valid (rx_out_valid),
        .out_data  (rx_out_data)
    );

    sync_fifo_thr u_tx_fifo (
        .clk       (clk),
        .rst_n     (rst_n_ff),
        .threshold (tx_threshold),
        .skip      (async_fifo_skip_on),
        .in_valid  (tx_in_valid),
        .in_data   (tx_in_data),
        .in_ready  (tx_in_ready),
        .out_valid (tx_out_valid),
        .out_data  (tx_out_data)
    );

    prbs_tx_checker u_checker (
        .clk                (clk),
        .rst_n              (rst_n_ff),
        .checker_on         (chk_ctrl_ff[phy_regs_pkg::CHECKER_ON_BIT]),
        .checker_count_mode (chk_ctrl_ff[phy_regs_pkg::COUNT_MODE_BIT]),
        .byte_valid         (checker_byte_valid),
        .byte_error         (checker_byte_error),
        .lock_pulse         (lock_pulse_ff),
        .lock_clear_pulse   (lock_clear_ff),
        .err_snap           (err_snap),
        .byte_snap          (byte_snap),
        .byte_overflow      (byte_overflow)
    );
endmodule : phy_fifo_an_prbs_regs
`default_nettype wire

// File: core/phy_regs_pkg.sv
// Constants for the FIFO control, serial negotiation status and PRBS checker registers.
// Assumes a 16-bit register port on the PHY internal clock of 100 MHz.
package phy_regs_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  RGMII_FIFO_CTRL_EXT_ADDR        = 8'h33;
    localparam logic [7:0]  SGMII_NEGOTIATION_STATUS_ADDR   = 8'h37;
    localparam logic [7:0]  PRBS_TX_CHECKER_CTRL_ADDR       = 8'h39;
    localparam logic [7:0]  PRBS_TX_CHECKER_BYTE_COUNT_ADDR = 8'h3A;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RGMII_FIFO_CTRL_EXT_RST         = 16'h0000;
    localparam logic [15:0] PRBS_TX_CHECKER_CTRL_RST        = 16'h0000;
    localparam logic [1:0]  THRESHOLD_LOW_BITS_RST          = 2'h2;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ASYNC_SKIP_BIT        = 4;
    localparam int ASYNC_SKIP_DELAY_BIT  = 3;
    localparam int LOW_LATENCY_BIT       = 2;
    localparam int RX_THR_TOP_BIT        = 1;
    localparam int TX_THR_TOP_BIT        = 0;
    localparam int PAGE_RX_BIT           = 1;
    localparam int NEG_DONE_BIT          = 0;
    localparam int ERR_CNT_LSB           = 7;
    localparam int ERR_CNT_MSB           = 14;
    localparam int LOCK_WR_BIT           = 7;
    localparam int LOCK_CLEAR_WR_BIT     = 8;
    localparam int SYNC_LOST_BIT         = 5;
    localparam int LOCKED_BIT            = 4;
    localparam int BYTE_OVF_BIT          = 2;
    localparam int COUNT_MODE_BIT        = 1;
    localparam int CHECKER_ON_BIT        = 0;
    // ------------------------------------------------------------------
    // Counts and FIFO geometry
    // ------------------------------------------------------------------
    localparam logic [7:0]  ERR_CNT_MAX  = 8'hFF;
    localparam logic [15:0] BYTE_CNT_MAX = 16'hFFFF;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          FIFO_AW      = 3;
    localparam int          FIFO_DW      = 8;
endpackage : phy_regs_pkg

// File: core/sync_fifo_thr.sv
// Eight-entry sync FIFO whose read starts once fill reaches twice the threshold.
// Assumes write and read on the same clock; the async path is modelled by the skip option.
`timescale 1ns/100ps
`default_nettype none
module sync_fifo_thr (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic [2:0]                        threshold,
    input  wire logic                              skip,
    input  wire logic                              in_valid,
    input  wire logic [phy_regs_pkg::FIFO_DW-1:0]  in_data,
    output logic                                   in_ready,
    output logic                                   out_valid,
    output logic      [phy_regs_pkg::FIFO_DW-1:0]  out_data
);
    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    logic [phy_regs_pkg::FIFO_DW-1:0] mem_ff [phy_regs_pkg::FIFO_DEPTH];
    logic [phy_regs_pkg::FIFO_AW:0]   wr_ptr_ff, nxt_wr_ptr;
    logic [phy_regs_pkg::FIFO_AW:0]   rd_ptr_ff, nxt_rd_ptr;
    logic                             reading_ff, nxt_reading;
    logic [phy_regs_pkg::FIFO_AW:0]   fill;
    logic [phy_regs_pkg::FIFO_AW:0]   start_level;
    logic                             do_wr;
    logic                             do_rd;

    always_comb begin
        fill        = wr_ptr_ff - rd_ptr_ff;
        // Twice the threshold; each step between 1 and 4 adds or removes two write cycles before the read starts
        start_level = {threshold, 1'b0};
        in_ready    = skip | (fill != 4'(phy_regs_pkg::FIFO_DEPTH));
        do_wr       = in_valid & in_ready & ~skip;
        nxt_reading = reading_ff;
        if (fill == 4'h0) begin
            nxt_reading = 1'b0;
        end else if (fill >= start_level) begin
            nxt_reading = 1'b1;
        end
        do_rd       = reading_ff & (fill != 4'h0) & ~skip;
        nxt_wr_ptr  = do_wr ? wr_ptr_ff + 4'h1 : wr_ptr_ff;
        nxt_rd_ptr  = do_rd ? rd_ptr_ff + 4'h1 : rd_ptr_ff;
        // Skip routes data straight past the storage
        out_valid   = skip ? in_valid : do_rd;
        out_data    = skip ? in_data : mem_ff[rd_ptr_ff[phy_regs_pkg::FIFO_AW-1:0]];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff  <= 4'h0;
            rd_ptr_ff  <= 4'h0;
            reading_ff <= 1'b0;
        end else begin
            wr_ptr_ff  <= nxt_wr_ptr;
            rd_ptr_ff  <= nxt_rd_ptr;
            reading_ff <= nxt_reading;
        end
    end

    // Storage has no reset; contents are only read once written
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff[phy_regs_pkg::FIFO_AW-1:0]] <= in_data;
        end
    end
endmodule : sync_fifo_thr
`default_nettype wire

// File: core/prbs_tx_checker.sv
// Counters of the transmit-side PRBS checker with lock and lock-clear snapshots.
// Assumes byte strobes and error flags from the checker datapath on the same clock.
`timescale 1ns/100ps
`default_nettype none
module prbs_tx_checker (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        checker_on,
    input  wire logic        checker_count_mode,
    input  wire logic        byte_valid,
    input  wire logic        byte_error,
    input  wire logic        lock_pulse,
    input  wire logic        lock_clear_pulse,
    output logic      [7:0]  err_snap,
    output logic      [15:0] byte_snap,
    output logic             byte_overflow
);
    logic [7:0]  err_cnt_ff, nxt_err_cnt;
    logic [15:0] byte_cnt_ff, nxt_byte_cnt;
    logic [7:0]  err_snap_ff, nxt_err_snap;
    logic [15:0] byte_snap_ff, nxt_byte_snap;
    logic        ovf_ff, nxt_ovf;

    always_comb begin
        nxt_err_cnt   = err_cnt_ff;
        nxt_byte_cnt  = byte_cnt_ff;
        nxt_err_snap  = err_snap_ff;
        nxt_byte_snap = byte_snap_ff;
        nxt_ovf       = ovf_ff;
        if (checker_on && byte_valid) begin
            // Single mode saturates, continuous mode wraps
            if (byte_cnt_ff == phy_regs_pkg::BYTE_CNT_MAX) begin
                nxt_ovf = 1'b1;
                if (checker_count_mode) begin
                    nxt_byte_cnt = 16'h0000;
                end
            end else begin
                nxt_byte_cnt = byte_cnt_ff + 16'h0001;
            end
            if (byte_error) begin
                if (err_cnt_ff != phy_regs_pkg::ERR_CNT_MAX) begin
                    nxt_err_cnt = err_cnt_ff + 8'h01;
                end else if (checker_count_mode) begin
                    nxt_err_cnt = 8'h00;
                end
            end
        end
        if (lock_pulse || lock_clear_pulse) begin
            nxt_err_snap  = err_cnt_ff;
            nxt_byte_snap = byte_cnt_ff;
        end
        if (lock_clear_pulse) begin
            nxt_err_cnt  = 8'h00;
            nxt_byte_cnt = 16'h0000;
            nxt_ovf      = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt_ff   <= 8'h00;
            byte_cnt_ff  <= 16'h0000;
            err_snap_ff  <= 8'h00;
            byte_snap_ff <= 16'h0000;
            ovf_ff       <= 1'b0;
        end else begin
            err_cnt_ff   <= nxt_err_cnt;
            byte_cnt_ff  <= nxt_byte_cnt;
            err_snap_ff  <= nxt_err_snap;
            byte_snap_ff <= nxt_byte_snap;
            ovf_ff       <= nxt_ovf;
        end
    end

    assign err_snap      = err_snap_ff;
    assign byte_snap     = byte_snap_ff;
    assign byte_overflow = ovf_ff;
endmodule : prbs_tx_checker
`default_nettype wire

// File: test/phy_fifo_an_prbs_regs_asserts.sv
// Concurrent checks on the register port, mode outputs and receive bypass.
// Bound to the top module; sees its ports only, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module phy_fifo_an_prbs_regs_asserts (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        rx_in_valid,
    input wire logic [7:0]  rx_in_data,
    input wire logic        rx_out_valid,
    input wire logic [7:0]  rx_out_data,
    input wire logic        async_fifo_skip_on,
    input wire logic        async_fifo_skip_delay_on,
    input wire logic        low_latency_on,
    input wire logic        checker_on
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wr33; reg_wr && reg_addr == 8'h33; endsequence
    sequence s_rd33; reg_rd && reg_addr == 8'h33; endsequence
    property p_skip; s_wr33 |=> async_fifo_skip_on == $past(reg_wdata[4]); endproperty
    a_skip: assert property (p_skip) else $error("skip output wrong");
    property p_dly; s_wr33 |=> async_fifo_skip_delay_on == $past(reg_wdata[3]); endproperty
    a_dly: assert property (p_dly) else $error("delay output wrong");
    property p_low; s_wr33 |=> low_latency_on == $past(reg_wdata[2]); endproperty
    a_low: assert property (p_low) else $error("low latency output wrong");
    property p_on; reg_wr && reg_addr == 8'h39 |=> checker_on == $past(reg_wdata[0]); endproperty
    a_on: assert property (p_on) else $error("checker enable wrong");
    property p_hold;
        !reg_wr |=> $stable({async_fifo_skip_on, async_fifo_skip_delay_on, low_latency_on});
    endproperty
    a_hold: assert property (p_hold) else $error("mode output moved");
    property p_rd33;
        s_rd33 |=> reg_rdata[15:2] == {11'h000, $past(async_fifo_skip_on),
            $past(async_fifo_skip_delay_on), $past(low_latency_on)};
    endproperty
    a_rd33: assert property (p_rd33) else $error("fifo control read wrong");
    property p_rd39;
        reg_rd && reg_addr == 8'h39 |=> reg_rdata[0] == $past(checker_on)
            && reg_rdata[15] == 1'b0 && reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0;
    endproperty
    a_rd39: assert property (p_rd39) else $error("checker control read wrong");
    property p_unmap;
        reg_rd && !(reg_addr inside {8'h33, 8'h37, 8'h39, 8'h3A}) |=> reg_rdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_byp;
        async_fifo_skip_on && rx_in_valid |-> rx_out_valid && rx_out_data == rx_in_data;
    endproperty
    a_byp: assert property (p_byp) else $error("bypass data wrong");
endmodule : phy_fifo_an_prbs_regs_asserts
bind phy_fifo_an_prbs_regs phy_fifo_an_prbs_regs_asserts i_chk (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
    .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
    .async_fifo_skip_on(async_fifo_skip_on), .async_fifo_skip_delay_on(async_fifo_skip_delay_on),
    .low_latency_on(low_latency_on), .checker_on(checker_on));
`default_nettype wire

// File: test/phy_fifo_an_prbs_regs_bench.sv
// Self-checking bench for the FIFO control, negotiation status and PRBS checker slice.
// Drives every port itself; the checker is attached by bind.
`timescale 1ns/100ps
`default_nettype none
module phy_fifo_an_prbs_regs_bench;
    logic        clk, rstn, reg_wr, reg_rd, page, neg, bv, be, sev, lck, rxv;
    logic        rxr, txr, rxo, txo, skip, dly, low, on;
    logic [7:0]  reg_addr, rxd, rxq, txq;
    logic [15:0] reg_wdata, reg_rdata;
    logic [1:0]  rxl, txl;
    logic [7:0]  addrs [5] = '{8'h33, 8'h37, 8'h39, 8'h3A, 8'h00};
    int          n_mismatch = 0;
    int          n_checks = 0;
    phy_fifo_an_prbs_regs i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_fifo_threshold_low_bits(rxl), .tx_fifo_threshold_low_bits(txl),
        .serial_page_received(page), .serial_link_negotiation_done(neg),
        .checker_byte_valid(bv), .checker_byte_error(be), .checker_sync_event(sev),
        .checker_lock_in(lck), .rx_in_valid(rxv), .rx_in_data(rxd), .rx_in_ready(rxr),
        .rx_out_valid(rxo), .rx_out_data(rxq), .tx_in_valid(rxv), .tx_in_data(rxd),
        .tx_in_ready(txr), .tx_out_valid(txo), .tx_out_data(txq), .async_fifo_skip_on(skip),
        .async_fifo_skip_delay_on(dly), .low_latency_on(low), .checker_on(on));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rd
    task automatic bytes(input int n, input logic e);
        @(posedge clk);
        bv <= 1'b1;
        be <= e;
        repeat (n) @(posedge clk);
        bv <= 1'b0;
    endtask : bytes
    // Both FIFOs run side by side; read start counted in edges from the first write
    task automatic fifo_case(input logic [2:0] thr);
        int need;
        int cnt;
        need = (thr == 3'h0) ? 1 : 2 * thr;
        cnt = 0;
        wr(8'h33, {14'h0, thr[2], thr[2]});
        rxl <= thr[1:0];
        txl <= thr[1:0];
        rxv <= 1'b1;
        rxd <= 8'h00;
        while (rxo !== 1'b1 && cnt < 40) begin
            @(posedge clk);
            if (cnt + 1 == need) rxv <= 1'b0;
            rxd <= 8'(cnt + 1);
            #1 cnt++;
            if (cnt == 8) chk("in_ready when full", {14'h0000, rxr, txr}, 16'h0000);
        end
        chk("read start", 16'(cnt), 16'(need + 1));
        chk("first valid", {14'h0000, txo, rxo}, 16'h0003);
        chk("first word", {txq, rxq}, 16'h0000);
        if (cnt >= 40) finish_test();
        repeat (12) @(posedge clk);
    endtask : fifo_case
    initial begin
        {rstn, reg_wr, reg_rd, page, neg, bv, be, sev, lck, rxv} = '0;
        {reg_addr, rxd, reg_wdata, rxl, txl} = '0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (addrs[i]) rd(addrs[i], 16'h0000);
        wr(8'h33, 16'hFFFF);
        rxv <= 1'b1;
        rxd <= 8'hA5;
        #1 chk("mode outputs", {13'h0000, skip, dly, low}, 16'h0007);
        @(posedge clk);
        #1 chk("bypass", {7'h00, rxo, rxq}, 16'h01A5);
        @(posedge clk);
        rxv <= 1'b0;
        rd(8'h33, 16'h001F);
        for (int t = 0; t < 5; t++) fifo_case(t[2:0]);
        $display("test registers and fifos done");
        // Single mode: error count stops at its maximum
        wr(8'h39, 16'h0101);
        bytes(300, 1'b1);
        wr(8'h39, 16'h0081);
        rd(8'h39, 16'h7F81);
        rd(8'h3A, 16'h012C);
        wr(8'h39, 16'h0103);
        rd(8'h3A, 16'h012C);
        // Continuous mode wraps and raises the overflow flag
        bytes(65537, 1'b0);
        wr(8'h39, 16'h0083);
        rd(8'h3A, 16'h0001);
        rd(8'h39, 16'h0007);
        wr(8'h39, 16'h0000);
        bytes(3, 1'b1);
        wr(8'h39, 16'h0080);
        rd(8'h39, 16'h0004);
        rd(8'h3A, 16'h0001);
        $display("test counters done");
        sev <= 1'b1;
        lck <= 1'b1;
        @(posedge clk);
        sev <= 1'b0;
        page <= 1'b1;
        neg <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h39, 16'h0034);
        rd(8'h39, 16'h0014);
        rd(8'h37, 16'h0003);
        rd(8'h37, 16'h0001);
        $display("test status flags done");
        finish_test();
    end
endmodule : phy_fifo_an_prbs_regs_bench
`default_nettype wire
